// >>> design/serial_boot_loader.sv
// Purpose: bootstrap serial loader, boot rom mapping and emulation pins
// Assumes: rxd and pins synchronous to mclk; arst_n is the power-on reset
// Notes:   bit periods are parameters so a simulation can shorten them
// Overview of operation
// - idle four characters ends the image reception at fast and slow rates
// - idle end armed only after sync character
// - wait without limit for the sync character
// - sync picks fast or slow receive rate
// - f0 and fd syncs pick extra rates
// - image from zero to 512 bytes
// - first byte zero jumps to eeprom start
// - echo every stored byte back to host
// - transmitter fed by a two-entry echo buffer plus shifter
// - emulation mode while reset and modes low
// - data pins follow emulation output enable pin
// - map bit resets set only in bootstrap
// - map bit set overlays boot rom reads
// - first character 55 at the fast rate jumps to ram
// - sync alone then idle jumps to ram
`timescale 1ns/10ps
module serial_boot_loader #(
    parameter int BIT_FAST = boot_loader_pkg::BIT_FAST_CYC,
    parameter int BIT_SLOW = boot_loader_pkg::BIT_SLOW_CYC,
    parameter int BIT_F0   = boot_loader_pkg::BIT_F0_CYC,
    parameter int BIT_FD_A = boot_loader_pkg::BIT_FD_A_CYC,
    parameter int BIT_FD_B = boot_loader_pkg::BIT_FD_B_CYC
) (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        arst_n,
    // mode pins and reset pin level
    input  wire logic                        mode_a,
    input  wire logic                        mode_b,
    input  wire logic                        reset_pin_n,
    // serial link
    input  wire logic                        rxd,
    output logic                             txd,
    // ram write port and exit
    output logic                             ram_wr,
    output boot_loader_pkg::ram_write_t      ram_port,
    output boot_loader_pkg::jump_t           jump,
    output logic                             echo_overrun,
    // cpu side of the map control
    input  wire logic                        map_wr,
    input  wire logic                        map_wdata,
    input  wire logic                        cpu_rd,
    input  wire logic [15:0]                 cpu_addr,
    input  wire logic [7:0]                  boot_rom_rdata,
    input  wire logic [7:0]                  prog_rdata,
    output logic [7:0]                       cpu_rdata,
    output logic                             boot_rom_map_enable,
    // emulation port
    input  wire logic                        emulation_output_enable_pin_n,
    input  wire logic [7:0]                  emu_rdata,
    input  wire logic [7:0]                  port_data_i,
    output logic [7:0]                       port_data_o,
    output logic                             port_data_oe,
    output logic [7:0]                       emu_wdata,
    output logic                             emulation_mode
);
    localparam int LOW_T1 = (BIT_FAST + BIT_FD_A) / 2;
    localparam int LOW_T2 = (BIT_FD_A + BIT_FD_B) / 2;
    localparam int LOW_T3 = (BIT_FD_B + 5 * BIT_F0) / 2;
    localparam int LOW_T4 = (5 * BIT_F0 + BIT_SLOW) / 2;

    boot_loader_pkg::load_state_t state;
    boot_loader_pkg::rate_t       rate;
    logic        strap_done;
    logic        boot_mode;
    logic        rxd_prev;
    logic        rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_idx;
    logic [7:0]  rx_shift;
    logic        rx_done;
    logic [7:0]  rx_data;
    logic [16:0] low_cnt;
    logic        classified;
    logic [15:0] idle_cnt;
    logic [7:0]  idle_bits;
    logic [9:0]  byte_count;
    logic        tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_idx;
    logic [8:0]  tx_shift;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [7:0]  fifo_out_data;

    // rate selection and its timing
    wire boot_loader_pkg::rate_t low_class =
        (low_cnt < 17'(LOW_T1)) ? boot_loader_pkg::RATE_FAST :
        (low_cnt < 17'(LOW_T2)) ? boot_loader_pkg::RATE_FD_A :
        (low_cnt < 17'(LOW_T3)) ? boot_loader_pkg::RATE_FD_B :
        (low_cnt < 17'(LOW_T4)) ? boot_loader_pkg::RATE_F0 : boot_loader_pkg::RATE_SLOW;
    wire [15:0] class_len =
        (low_class == boot_loader_pkg::RATE_SLOW) ? 16'(BIT_SLOW) :
        (low_class == boot_loader_pkg::RATE_F0)   ? 16'(BIT_F0)   :
        (low_class == boot_loader_pkg::RATE_FD_A) ? 16'(BIT_FD_A) :
        (low_class == boot_loader_pkg::RATE_FD_B) ? 16'(BIT_FD_B) : 16'(BIT_FAST);
    wire [15:0] bit_len =
        (rate == boot_loader_pkg::RATE_SLOW) ? 16'(BIT_SLOW) :
        (rate == boot_loader_pkg::RATE_F0)   ? 16'(BIT_F0)   :
        (rate == boot_loader_pkg::RATE_FD_A) ? 16'(BIT_FD_A) :
        (rate == boot_loader_pkg::RATE_FD_B) ? 16'(BIT_FD_B) : 16'(BIT_FAST);
    wire [7:0] idle_limit =
        (rate == boot_loader_pkg::RATE_F0)   ? boot_loader_pkg::IDLE_BITS_F0   :
        (rate == boot_loader_pkg::RATE_FD_A) ? boot_loader_pkg::IDLE_BITS_FD_A :
        (rate == boot_loader_pkg::RATE_FD_B) ? boot_loader_pkg::IDLE_BITS_FD_B :
        boot_loader_pkg::IDLE_BITS_STD;

    // decode of loader events
    wire in_sync     = state == boot_loader_pkg::ST_SYNC;
    wire in_load     = state == boot_loader_pkg::ST_LOAD;
    wire rx_enable   = in_sync | in_load;
    wire rx_fall     = rxd_prev & ~rxd;
    wire rx_tick     = rx_cnt == 16'h0000;
    wire classify    = in_sync & ~classified & rxd & (low_cnt != 17'h0_0000);
    wire retime      = classify & (low_class != boot_loader_pkg::RATE_FAST);
    wire [3:0] resume_idx = (low_class == boot_loader_pkg::RATE_F0) ?
        boot_loader_pkg::F0_RESUME_IDX : boot_loader_pkg::STD_RESUME_IDX;
    wire first_byte  = byte_count == 10'h000;
    wire zero_first  = in_load & rx_done & first_byte & (rx_data == boot_loader_pkg::FIRST_TO_EEPROM);
    wire sync_to_ram = in_sync & rx_done & (rate == boot_loader_pkg::RATE_FAST)
                     & (rx_data == boot_loader_pkg::FIRST_TO_RAM);
    wire idle_line   = ~rx_busy & rxd;
    wire timeout     = in_load & (idle_bits == idle_limit);
    wire echo_push   = in_load & rx_done & ~zero_first;
    wire image_room  = byte_count < boot_loader_pkg::IMAGE_MAX;
    wire tx_take     = ~tx_busy & fifo_out_valid;

    // straps caught after reset release
    // map bit reset value
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            strap_done          <= 1'b0;
            boot_mode           <= 1'b0;
            boot_rom_map_enable <= 1'b0;
        end else if (!strap_done) begin
            strap_done          <= 1'b1;
            boot_mode           <= ~mode_a & ~mode_b;
            boot_rom_map_enable <= ~mode_a & ~mode_b;
        end else if (map_wr && boot_mode) begin
            boot_rom_map_enable <= map_wdata;
        end
    end

    wire rom_hit = boot_rom_map_enable
                 & ((cpu_addr & boot_loader_pkg::BOOT_ROM_MASK) == boot_loader_pkg::BOOT_ROM_BASE);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd) begin
            cpu_rdata <= rom_hit ? boot_rom_rdata : prog_rdata;
        end
    end

    wire emul_now = ~reset_pin_n & ~mode_a & ~mode_b;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            emulation_mode <= 1'b0;
            port_data_oe   <= 1'b0;
            port_data_o    <= 8'h00;
            emu_wdata      <= 8'h00;
        end else begin
            emulation_mode <= emul_now;
            port_data_oe   <= emul_now & ~emulation_output_enable_pin_n;
            port_data_o    <= emu_rdata;
            if (emul_now && emulation_output_enable_pin_n) begin
                emu_wdata <= port_data_i;
            end
        end
    end

    // serial receiver, re-timed when the sync picks a new rate
    // resume at new rate
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rxd_prev <= 1'b1;
            rx_busy  <= 1'b0;
            rx_cnt   <= 16'h0000;
            rx_idx   <= 4'h0;
            rx_shift <= 8'h00;
            rx_done  <= 1'b0;
            rx_data  <= 8'h00;
        end else begin
            rxd_prev <= rxd;
            rx_done  <= 1'b0;
            if (retime) begin
                rx_busy  <= 1'b1;
                rx_idx   <= resume_idx;
                rx_cnt   <= class_len >> 1;
                rx_shift <= 8'h00;
            end else if (!rx_busy) begin
                if (rx_fall && rx_enable) begin
                    rx_busy <= 1'b1;
                    rx_idx  <= 4'h0;
                    rx_cnt  <= bit_len >> 1;
                end
            end else if (!rx_tick) begin
                rx_cnt <= rx_cnt - 16'h0001;
            end else begin
                rx_cnt <= bit_len - 16'h0001;
                if (rx_idx == 4'h0) begin
                    rx_busy <= ~rxd;
                    rx_idx  <= 4'h1;
                end else if (rx_idx == boot_loader_pkg::FRAME_STOP_IDX) begin
                    rx_busy <= 1'b0;
                    rx_done <= rxd;
                    rx_data <= rx_shift;
                end else begin
                    rx_shift <= {rxd, rx_shift[7:1]};
                    rx_idx   <= rx_idx + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt    <= 17'h0_0000;
            classified <= 1'b0;
            rate       <= boot_loader_pkg::RATE_FAST;
        end else if (classify) begin
            classified <= 1'b1;
            rate       <= low_class;
        end else if (in_sync && !classified && !rxd && low_cnt != 17'h1_ffff) begin
            low_cnt <= low_cnt + 17'h0_0001;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            idle_cnt  <= 16'h0000;
            idle_bits <= 8'h00;
        end else if (!in_load || !idle_line) begin
            idle_cnt  <= 16'h0000;
            idle_bits <= 8'h00;
        end else if (idle_cnt == bit_len - 16'h0001) begin
            idle_cnt  <= 16'h0000;
            idle_bits <= idle_bits + 8'h01;
        end else begin
            idle_cnt <= idle_cnt + 16'h0001;
        end
    end

    // loader sequence
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= boot_loader_pkg::ST_IDLE;
            jump  <= '0;
        end else begin
            unique case (state)
                boot_loader_pkg::ST_IDLE: begin
                    if (strap_done && boot_mode) begin
                        state <= boot_loader_pkg::ST_SYNC;
                    end
                end
                boot_loader_pkg::ST_SYNC: begin
                    if (sync_to_ram) begin
                        state <= boot_loader_pkg::ST_DONE;
                        jump  <= '{valid: 1'b1, addr: boot_loader_pkg::RAM_START};
                    end else if (rx_done) begin
                        state <= boot_loader_pkg::ST_LOAD;
                    end
                end
                boot_loader_pkg::ST_LOAD: begin
                    if (zero_first) begin
                        state <= boot_loader_pkg::ST_DONE;
                        jump  <= '{valid: 1'b1, addr: boot_loader_pkg::JUMP_EEPROM};
                    end else if (timeout) begin
                        state <= boot_loader_pkg::ST_DONE;
                        jump  <= '{valid: 1'b1, addr: boot_loader_pkg::RAM_START};
                    end
                end
                boot_loader_pkg::ST_DONE: begin
                    state <= boot_loader_pkg::ST_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            byte_count   <= 10'h000;
            ram_wr       <= 1'b0;
            ram_port     <= '0;
            echo_overrun <= 1'b0;
        end else begin
            ram_wr <= echo_push & image_room;
            if (echo_push && image_room) begin
                ram_port   <= '{addr: byte_count[8:0], data: rx_data};
                byte_count <= byte_count + 10'h001;
            end
            if (echo_push && !fifo_in_ready) begin
                echo_overrun <= 1'b1;
            end
        end
    end

    echo_buffer #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_echo (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .in_valid  (echo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_data),
        .out_valid (fifo_out_valid),
        .out_ready (~tx_busy),
        .out_data  (fifo_out_data)
    );

    // transmit shifter
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            txd      <= 1'b1;
            tx_busy  <= 1'b0;
            tx_cnt   <= 16'h0000;
            tx_idx   <= 4'h0;
            tx_shift <= 9'h1ff;
        end else if (tx_take) begin
            txd      <= 1'b0;
            tx_busy  <= 1'b1;
            tx_cnt   <= bit_len - 16'h0001;
            tx_idx   <= 4'h0;
            tx_shift <= {1'b1, fifo_out_data};
        end else if (tx_busy && tx_cnt != 16'h0000) begin
            tx_cnt <= tx_cnt - 16'h0001;
        end else if (tx_busy) begin
            tx_cnt <= bit_len - 16'h0001;
            if (tx_idx == boot_loader_pkg::FRAME_STOP_IDX) begin
                tx_busy <= 1'b0;
            end else begin
                txd      <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[8:1]};
                tx_idx   <= tx_idx + 4'h1;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_first_zero;
        in_load && rx_done && first_byte && rx_data == 8'h00;
    endsequence

    sequence s_eeprom_exit;
        state == boot_loader_pkg::ST_DONE && jump.valid && jump.addr == 16'hb600;
    endsequence

    a_idle_end_exit: assert property (timeout && !zero_first |=>
        state == boot_loader_pkg::ST_DONE && jump.addr == 16'h0000)
        else $error("idle timeout did not end the download");
    a_sync_no_timeout: assert property (in_sync && !rx_done |=>
        state == boot_loader_pkg::ST_SYNC)
        else $error("loader left sync wait without a character");
    a_zero_first_jump: assert property (s_first_zero |=> s_eeprom_exit)
        else $error("zero first byte did not jump to eeprom");
    a_echo_on_store: assert property (in_load && rx_done && !first_byte |->
        echo_push)
        else $error("stored byte not queued for echo");
    a_tx_start_bit: assert property (tx_take |=> !txd && tx_busy [*2])
        else $error("echo frame did not begin with a start bit");
    a_ram_sequential: assert property (ram_wr |->
        ram_port.addr == 9'(byte_count - 10'h001))
        else $error("ram address not sequential");
    a_image_limit: assert property (!image_room |=> !ram_wr)
        else $error("store beyond image size");
    a_map_protect: assert property (strap_done && !boot_mode |->
        !boot_rom_map_enable)
        else $error("map bit set outside bootstrap");
    a_rom_overlay: assert property (cpu_rd && rom_hit |=>
        cpu_rdata == $past(boot_rom_rdata))
        else $error("overlay read did not return boot rom");
    a_emul_dir: assert property (port_data_oe |-> emulation_mode &&
        !$past(emulation_output_enable_pin_n))
        else $error("data pins driven outside emulation read");
    a_ram_jump: assert property (sync_to_ram |=> jump.valid &&
        jump.addr == 16'h0000 && !ram_wr)
        else $error("sync 55 did not jump to ram");
endmodule

// >>> design/boot_loader_pkg.sv
// Purpose: shared constants, types and carriers of the serial boot loader
// Assumes: 50 MHz mclk; serial frame of start, eight data bits, stop
// Notes:   bit periods are cycle counts derived from the baud figures
package boot_loader_pkg;

    // clock and baud figures
    localparam int CLK_HZ        = 50_000_000;
    localparam int BAUD_FAST_X2  = 15625;    // 7812.5 baud, doubled to stay integral
    localparam int BAUD_SLOW     = 1200;
    localparam int BAUD_ALT_F0   = 9600;
    localparam int BAUD_ALT_FD_A = 5208;
    localparam int BAUD_ALT_FD_B = 3906;

    // bit periods in mclk cycles
    localparam int BIT_FAST_CYC = (CLK_HZ * 2) / BAUD_FAST_X2;
    localparam int BIT_SLOW_CYC = CLK_HZ / BAUD_SLOW;
    localparam int BIT_F0_CYC   = CLK_HZ / BAUD_ALT_F0;
    localparam int BIT_FD_A_CYC = CLK_HZ / BAUD_ALT_FD_A;
    localparam int BIT_FD_B_CYC = CLK_HZ / BAUD_ALT_FD_B;

    // idle end limits in bit periods (tenths of a ten-bit character)
    localparam logic [7:0] IDLE_BITS_STD  = 8'h28;   // 4 characters
    localparam logic [7:0] IDLE_BITS_F0   = 8'h31;   // 4.9 characters
    localparam logic [7:0] IDLE_BITS_FD_A = 8'had;   // 17.3 characters
    localparam logic [7:0] IDLE_BITS_FD_B = 8'h82;   // 13 characters

    // frame layout
    localparam logic [3:0] FRAME_STOP_IDX = 4'h9;
    localparam logic [3:0] F0_RESUME_IDX  = 4'h5;
    localparam logic [3:0] STD_RESUME_IDX = 4'h1;

    // characters with a meaning
    localparam logic [7:0] SYNC_STD        = 8'hff;
    localparam logic [7:0] SYNC_F0         = 8'hf0;
    localparam logic [7:0] SYNC_FD         = 8'hfd;
    localparam logic [7:0] FIRST_TO_EEPROM = 8'h00;
    localparam logic [7:0] FIRST_TO_RAM    = 8'h55;

    // addresses and sizes
    localparam logic [15:0] JUMP_EEPROM   = 16'hb600;
    localparam logic [15:0] RAM_START     = 16'h0000;
    localparam logic [9:0]  IMAGE_MAX     = 10'h200;
    localparam logic [15:0] BOOT_ROM_BASE = 16'hbf00;
    localparam logic [15:0] BOOT_ROM_MASK = 16'hff00;

    typedef enum logic [2:0] {
        RATE_FAST = 3'b000,
        RATE_SLOW = 3'b001,
        RATE_F0   = 3'b010,
        RATE_FD_A = 3'b011,
        RATE_FD_B = 3'b100
    } rate_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SYNC = 2'b01,
        ST_LOAD = 2'b10,
        ST_DONE = 2'b11
    } load_state_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
    } ram_write_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } jump_t;

endpackage

// >>> design/echo_buffer.sv
// Purpose: small valid/ready buffer between receiver and transmitter
// Assumes: DEPTH of at least two
// Notes:   full and empty follow the occupancy count exactly
`timescale 1ns/10ps
module echo_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    fill;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = fill != FULL;
    assign out_valid = fill != '0;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// >>> dv/host_model.sv
// Purpose: host side, sends serial bytes and collects echoes
// Assumes: 8N1, lsb first, line idles high
// Notes:   bit length in mclk cycles per call
`timescale 1ns/10ps
module host_model (
    // clock
    input  wire logic mclk,
    // serial link
    output logic      rxd,
    input  wire logic txd
);
    int         echo_bit = 16;
    logic [7:0] echo_q[$];
    logic [7:0] sh;
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] b, input int bl);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (bl) @(negedge mclk);
        end
    endtask
    always begin
        @(negedge txd);
        repeat (echo_bit + echo_bit / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            sh[i] = txd;
            repeat (echo_bit) @(posedge mclk);
        end
        echo_q.push_back(sh);
    end
endmodule

// >>> dv/tb.sv
// Purpose: self-checking bench of the serial boot loader
// Assumes: short bit periods set by parameters
// Notes:   rate rows first, then hand-written cases
`timescale 1ns/10ps
module tb;
    typedef struct {
        logic [7:0] sync;
        int         bl;
        int         idle;
    } row_t;
    row_t rows[5] = '{'{8'hff, 16, 40}, '{8'hff, 100, 40}, '{8'hf0, 13, 49},
                      '{8'hfd, 24, 173}, '{8'hfd, 32, 130}};
    logic [7:0] dat[4] = '{8'h01, 8'h80, 8'ha5, 8'h3c};
    logic mclk, arst_n, mode_a, mode_b, reset_pin_n, rxd, txd, ram_wr, ovr;
    logic map_wr, map_wdata, cpu_rd, map_en, oe_n, port_oe, emu_mode;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_rdata, port_o, emu_wdata, rom_d, prog_d, emu_d, pin_d;
    boot_loader_pkg::ram_write_t ram_port;
    boot_loader_pkg::jump_t      jump;
    boot_loader_pkg::ram_write_t ram_q[$];
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    host_model host (.mclk(mclk), .rxd(rxd), .txd(txd));
    serial_boot_loader #(.BIT_FAST(16), .BIT_SLOW(100), .BIT_F0(13), .BIT_FD_A(24),
        .BIT_FD_B(32)) dut (.mclk(mclk), .arst_n(arst_n), .mode_a(mode_a),
        .mode_b(mode_b), .reset_pin_n(reset_pin_n), .rxd(rxd), .txd(txd),
        .ram_wr(ram_wr), .ram_port(ram_port), .jump(jump), .echo_overrun(ovr),
        .map_wr(map_wr), .map_wdata(map_wdata), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .boot_rom_rdata(rom_d), .prog_rdata(prog_d), .cpu_rdata(cpu_rdata),
        .boot_rom_map_enable(map_en), .emulation_output_enable_pin_n(oe_n),
        .emu_rdata(emu_d), .port_data_i(pin_d), .port_data_o(port_o),
        .port_data_oe(port_oe), .emu_wdata(emu_wdata), .emulation_mode(emu_mode));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (ram_wr === 1'b1) ram_q.push_back(ram_port);
        if (cyc == 90000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rst(input logic ma);
        arst_n = 1'b0;
        mode_a = ma;
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
        repeat (3) @(negedge mclk);
        ram_q.delete();
        host.echo_q.delete();
    endtask
    task automatic wait_jump();
        n = 0;
        while (jump.valid !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        cpu_rd = 1'b1;
        cpu_addr = a;
        @(negedge mclk);
        cpu_rd = 1'b0;
        @(negedge mclk);
        check("cpu_rdata", e, cpu_rdata);
    endtask
    task automatic report_and_stop();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        {mode_a, mode_b, map_wr, map_wdata, cpu_rd, arst_n} = '0;
        {reset_pin_n, oe_n} = 2'b11;
        cpu_addr = 16'h0000;
        {rom_d, prog_d, emu_d, pin_d} = 32'hb09e_5ac3;
        foreach (rows[i]) begin
            rst(1'b0);
            host.echo_bit = rows[i].bl;
            host.send(rows[i].sync, rows[i].bl);
            host.send(8'h3c, rows[i].bl);
            wait_jump();
            check("idle_lo", 1, n > (rows[i].idle - 3) * rows[i].bl);
            check("idle_hi", 1, n < (rows[i].idle + 3) * rows[i].bl);
            check("ram", {9'h000, 8'h3c}, ram_q.size() == 1 ? ram_q[0] : 17'h0);
            check("echo", 8'h3c, host.echo_q.size() == 1 ? host.echo_q[0] : 8'h00);
        end
        rst(1'b0);
        host.echo_bit = 16;
        check("map_reset", 1'b1, map_en);
        repeat (3000) @(negedge mclk);
        check("no_limit", 1'b0, jump.valid);
        host.send(8'hff, 16);
        foreach (dat[i]) host.send(dat[i], 16);
        wait_jump();
        check("jump", {1'b1, 16'h0000}, jump);
        check("count", {16'h0004, 16'h0004}, {16'(ram_q.size()), 16'(host.echo_q.size())});
        foreach (dat[i]) check("ram", {i[8:0], dat[i]}, ram_q[i]);
        check("overrun", 1'b0, ovr);
        rd(16'hbf00, 8'hb0);
        rd(16'hbeff, 8'h9e);
        rom_d = 8'h4b;
        rd(16'hbfff, 8'h4b);
        map_wr = 1'b1;
        @(negedge mclk);
        map_wr = 1'b0;
        check("map_clear", 1'b0, map_en);
        rd(16'hbf00, 8'h9e);
        rst(1'b0);
        host.send(8'hff, 16);
        wait_jump();
        check("sync_only", 1, n > 37 * 16 && jump.addr === 16'h0000);
        rst(1'b0);
        host.send(8'hff, 16);
        host.send(8'h00, 16);
        wait_jump();
        check("to_eeprom", {1'b1, 16'hb600, 10'h000}, {jump, 10'(ram_q.size())});
        rst(1'b0);
        host.send(8'h55, 16);
        wait_jump();
        check("to_ram", {1'b1, 16'h0000, 1'b1}, {jump, n < 200 && ram_q.size() == 0});
        rst(1'b1);
        map_wdata = 1'b1;
        map_wr = 1'b1;
        @(negedge mclk);
        map_wr = 1'b0;
        @(negedge mclk);
        check("map_locked", 1'b0, map_en);
        mode_a = 1'b0;
        reset_pin_n = 1'b0;
        oe_n = 1'b0;
        repeat (2) @(negedge mclk);
        check("emu_on", 2'b11, {emu_mode, port_oe});
        check("emu_rd", 8'h5a, port_o);
        oe_n = 1'b1;
        pin_d = 8'h3c;
        emu_d = 8'ha7;
        repeat (2) @(negedge mclk);
        check("emu_hiz", 2'b10, {emu_mode, port_oe});
        check("emu_pins", {8'h3c, 8'ha7}, {emu_wdata, port_o});
        mode_b = 1'b1;
        pin_d = 8'h11;
        repeat (2) @(negedge mclk);
        check("emu_off", {1'b0, 8'h3c}, {emu_mode, emu_wdata});
        report_and_stop();
    end
endmodule
